// File: sync_transfer_handshake.v
// Synchronous transfer handshake sequencer between drive and controller
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Up: follow line frequency, lock three seconds
// - After lock interval raise up permit
// - Line ack in up transfer: up done
// - Down permit only with enough voltage
// - Down: wait five seconds for stabilising
// - Lock, torque 25 percent, then unlatch
// - Line ack cleared: down done
// - Done clears permit, unlatch; enter run
// - Up transfer uses phase offset setpoint
// - Up lock only within error window
// - Down transfer applies frequency offset
// - Timeout in down: fail, warning, need reset
// - Fault: coast stop, idle, need reset
`include "sync_xfer_regs.vh"
module sync_transfer_handshake
#(
	parameter LOCK_TICKS = `LOCK_MS * `TICK_HZ / 1000,
	parameter STAB_TICKS = `STAB_MS * `TICK_HZ / 1000,
	parameter XFER_TO_TICKS = `XFER_TO_MS * `TICK_HZ / 1000,
	parameter TICK_CYCLES = `TICK_DIV
)
(
	input  wire        ref_clk_i,
	input  wire        rst_n_i,
	input  wire        to_line_request_i,
	input  wire        to_drive_request_i,
	input  wire        run_request_in_i,
	input  wire        output_contactor_closed_ack_i,
	input  wire        line_contactor_closed_ack_i,
	input  wire        drive_fault_i,
	input  wire        voltage_ok_i,
	input  wire        phase_in_window_i,
	input  wire        freq_locked_i,
	input  wire [7:0]  torque_pct_i,
	input  wire [3:0]  addr_i,
	input  wire [15:0] wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output reg  [15:0] rdata_o,
	output reg         to_line_permit_o,
	output reg         to_line_done_o,
	output reg         mains_contactor_open_cmd_o,
	output reg         to_drive_permit_o,
	output reg         to_drive_done_o,
	output reg         track_line_o,
	output reg         coast_stop_o,
	output reg         run_enable_o,
	output reg         xfer_fail_warn_o,
	output reg  [15:0] phase_setpoint_o,
	output reg  [15:0] phase_window_o,
	output reg  [15:0] freq_offset_o
);

localparam S_IDLE    = 4'h0;
localparam S_RUN     = 4'h1;
localparam S_UP_LOCK = 4'h2;
localparam S_UP_PERM = 4'h3;
localparam S_UP_DONE = 4'h4;
localparam S_DN_INIT = 4'h5;
localparam S_DN_STAB = 4'h6;
localparam S_DN_TORQ = 4'h7;
localparam S_DN_DONE = 4'h8;
localparam S_FAULT   = 4'h9;
localparam S_FAIL    = 4'ha;

// Clamp a signed tenths value into +/- limit
function [15:0] clamp;
	input [15:0] v;
	input [15:0] lim;
	input        unsig;
	clamp = (unsig && v[15]) ? 16'h0000 :
		(!v[15] && v > lim) ? lim :
		(v[15] && (16'h0000 - v) > lim) ? 16'h0000 - lim : v;
endfunction

// Two-flop synchronisers on all pin inputs except reset and the register bus
wire [16:0] pins_raw = {torque_pct_i, to_drive_request_i, to_line_request_i,
	drive_fault_i, voltage_ok_i, phase_in_window_i, freq_locked_i,
	line_contactor_closed_ack_i, output_contactor_closed_ack_i,
	run_request_in_i};
reg  [16:0] meta;
reg  [16:0] sync;
always @(posedge ref_clk_i)
begin
	meta <= pins_raw;
	sync <= meta;
end

// Control tick divider
reg [16:0] div;
reg        tick;
always @(posedge ref_clk_i)
begin
	tick <= rst_n_i && (div == TICK_CYCLES - 1);
	if (!rst_n_i || div == TICK_CYCLES - 1)
		div <= 17'h00000;
	else
		div <= div + 17'h00001;
end

// Per-tick sample; accept only values equal on two ticks
reg [8:0] samp_a;
reg [8:0] samp;
wire [8:0] raw_now = sync[8:0];
always @(posedge ref_clk_i)
begin
	if (!rst_n_i)
	begin
		samp_a <= 9'h000;
		samp   <= 9'h000;
	end
	else if (tick)
	begin
		samp_a <= raw_now;
		if (samp_a == raw_now)
			samp <= raw_now;
	end
end
wire run_rq   = samp[0];
wire oc_ack   = samp[1];
wire lc_ack   = samp[2];
wire f_lock   = samp[3];
wire ph_ok    = samp[4];
wire volt_ok  = samp[5];
wire fault    = samp[6];
wire up_rq    = samp[7];
wire dn_rq    = samp[8];

// Registers
reg [1:0]  ctrl;
reg [15:0] ph_ofs;
reg [15:0] ph_win;
reg [15:0] fr_ofs;
reg        fault_rst;
always @(posedge ref_clk_i)
begin
	if (!rst_n_i)
	begin
		ctrl   <= 2'h0;
		ph_ofs <= `RV_PHASE_OFS;
		ph_win <= `RV_PHASE_WIN;
		fr_ofs <= `RV_FREQ_OFS;
		fault_rst <= 1'b0;
	end
	else
	begin
		if (wr_i && addr_i == `A_CTRL && wdata_i[`C_FAULT_RST])
			fault_rst <= 1'b1;
		else if (tick)
			fault_rst <= 1'b0;
		if (wr_i && addr_i == `A_CTRL)
			ctrl[`C_INHIBIT] <= wdata_i[`C_INHIBIT];
		if (wr_i && addr_i == `A_PHASE_OFS)
			ph_ofs <= clamp(wdata_i, `LIM_PHASE_OFS, 1'b0);
		if (wr_i && addr_i == `A_PHASE_WIN)
			ph_win <= clamp(wdata_i, `LIM_PHASE_WIN, 1'b1);
		if (wr_i && addr_i == `A_FREQ_OFS)
			fr_ofs <= clamp(wdata_i, `LIM_FREQ_OFS, 1'b0);
	end
end

// Sequencer
reg [3:0]  state;
reg [3:0]  next_state;
reg [15:0] cnt;
reg [15:0] to_cnt;
reg        warn;
wire intv_done_lock = (cnt >= LOCK_TICKS - 1);
wire intv_done_stab = (cnt >= STAB_TICKS - 1);

always @*
begin
	next_state = state;
	case (state)
	S_IDLE:
		if (up_rq && !dn_rq && run_rq && oc_ack && !lc_ack)
			next_state = S_UP_LOCK;
		else if (dn_rq && !up_rq && lc_ack && run_rq && volt_ok && !warn)
			next_state = S_DN_INIT;
		else if (run_rq && oc_ack && !up_rq && !dn_rq)
			next_state = S_RUN;
	S_RUN:
		if (!run_rq)
			next_state = S_IDLE;
		else if (up_rq && oc_ack)
			next_state = S_UP_LOCK;
	S_UP_LOCK:
		if (!up_rq || !oc_ack || !run_rq)
			next_state = run_rq ? S_RUN : S_IDLE;
		else if (intv_done_lock && ph_ok)
			next_state = S_UP_PERM;
	S_UP_PERM:
		if (lc_ack)
			next_state = S_UP_DONE;
		else if (!up_rq || !oc_ack || !run_rq)
			next_state = run_rq ? S_RUN : S_IDLE;
	S_UP_DONE:
		if (!up_rq && !oc_ack && !lc_ack && !run_rq)
			next_state = S_IDLE;
	S_DN_INIT:
		if (oc_ack)
			next_state = S_DN_STAB;
	S_DN_STAB:
		if (!oc_ack)
			next_state = S_DN_INIT;
		else if (intv_done_stab)
			next_state = S_DN_TORQ;
	S_DN_TORQ:
		if (!lc_ack)
			next_state = S_DN_DONE;
	S_DN_DONE:
		if (!dn_rq)
			next_state = run_rq ? S_RUN : S_IDLE;
	S_FAULT:
		if (fault_rst && !fault)
			next_state = S_IDLE;
	S_FAIL:
		if (fault_rst)
			next_state = S_IDLE;
	default:
		next_state = S_IDLE;
	endcase
	if (fault)
		next_state = S_FAULT;
	else if (ctrl[`C_INHIBIT])
		next_state = S_IDLE;
	else if ((state == S_DN_INIT || state == S_DN_STAB
		|| state == S_DN_TORQ) && to_cnt >= XFER_TO_TICKS - 1)
		next_state = S_FAIL;
end

always @(posedge ref_clk_i)
begin
	if (!rst_n_i)
	begin
		state  <= S_IDLE;
		cnt    <= 16'h0000;
		to_cnt <= 16'h0000;
		warn   <= 1'b0;
	end
	else if (tick)
	begin
		state <= next_state;
		if (next_state != state || (state == S_UP_LOCK && !ph_ok))
			cnt <= 16'h0000;
		else if (cnt != 16'hffff)
			cnt <= cnt + 16'h0001;
		if (next_state != S_DN_INIT && next_state != S_DN_STAB
			&& next_state != S_DN_TORQ)
			to_cnt <= 16'h0000;
		else if (to_cnt != 16'hffff)
			to_cnt <= to_cnt + 16'h0001;
		if (next_state == S_FAIL)
			warn <= 1'b1;
		else if (fault_rst)
			warn <= 1'b0;
	end
end

// Torque build done once locked at 25 percent
wire torque_ok = f_lock && (sync[16:9] >= `IQ_PCT);
reg  unlatch;
always @(posedge ref_clk_i)
	unlatch <= rst_n_i && (state == S_DN_TORQ)
		&& (unlatch || (tick && torque_ok));

// Registered outputs
always @(posedge ref_clk_i)
begin
	if (!rst_n_i)
	begin
		to_line_permit_o <= 1'b0;
		to_line_done_o <= 1'b0;
		mains_contactor_open_cmd_o <= 1'b0;
		to_drive_permit_o <= 1'b0;
		to_drive_done_o <= 1'b0;
		track_line_o <= 1'b0;
		coast_stop_o <= 1'b0;
		run_enable_o <= 1'b0;
		xfer_fail_warn_o <= 1'b0;
		phase_setpoint_o <= 16'h0000;
		phase_window_o <= 16'h0000;
		freq_offset_o <= 16'h0000;
		rdata_o <= 16'h0000;
	end
	else
	begin
		to_line_permit_o <= (state == S_UP_PERM);
		to_line_done_o <= (state == S_UP_DONE);
		mains_contactor_open_cmd_o <= unlatch;
		to_drive_permit_o <= (state == S_DN_INIT || state == S_DN_STAB
			|| state == S_DN_TORQ);
		to_drive_done_o <= (state == S_DN_DONE);
		track_line_o <= (state == S_UP_LOCK || state == S_UP_PERM
			|| state == S_DN_STAB || state == S_DN_TORQ);
		coast_stop_o <= (state == S_FAULT);
		run_enable_o <= (state == S_RUN || state == S_UP_LOCK
			|| state == S_UP_PERM || state == S_DN_INIT
			|| state == S_DN_STAB || state == S_DN_TORQ
			|| state == S_DN_DONE);
		xfer_fail_warn_o <= warn;
		phase_setpoint_o <= (state == S_UP_LOCK || state == S_UP_PERM)
			? ph_ofs : 16'h0000;
		phase_window_o <= ph_win;
		freq_offset_o <= (state == S_DN_TORQ) ? fr_ofs : 16'h0000;
		if (rd_i)
		begin
			case (addr_i)
			`A_CTRL:      rdata_o <= {14'h0000, ctrl};
			`A_STATUS:    rdata_o <= {6'h00, warn, samp};
			`A_PHASE_OFS: rdata_o <= ph_ofs;
			`A_PHASE_WIN: rdata_o <= ph_win;
			`A_FREQ_OFS:  rdata_o <= fr_ofs;
			`A_STATE:     rdata_o <= {12'h000, state};
			default:      rdata_o <= 16'h0000;
			endcase
		end
		else
			rdata_o <= 16'h0000;
	end
end

endmodule // sync_transfer_handshake
`default_nettype wire

// File: sync_xfer_regs.vh
// Constants for the synchronous transfer handshake sequencer
`ifndef SYNC_XFER_REGS_VH
`define SYNC_XFER_REGS_VH
// Register indices (byte address = index, plain port)
`define A_CTRL        4'h0
`define A_STATUS      4'h1
`define A_PHASE_OFS   4'h2
`define A_PHASE_WIN   4'h3
`define A_FREQ_OFS    4'h4
`define A_STATE       4'h5
// Control bits
`define C_FAULT_RST   0
`define C_INHIBIT     1
// Reset values and limits, tenths of a unit, signed 16 bit
`define RV_PHASE_OFS  16'h0014
`define RV_PHASE_WIN  16'h000f
`define RV_FREQ_OFS   16'h0005
`define LIM_PHASE_OFS 16'h0384
`define LIM_PHASE_WIN 16'h0032
`define LIM_FREQ_OFS  16'h0064
// Timing
`define CLK_HZ        100000000
`define TICK_HZ       1000
`define TICK_DIV      (`CLK_HZ / `TICK_HZ)
`define LOCK_MS       3000
`define STAB_MS       5000
`define XFER_TO_MS    30000
// Torque threshold, percent of maximum current
`define IQ_PCT        8'h19
`endif

// File: sync_transfer_handshake_sva.sv
// Checker for the transfer handshake sequencer ports
`timescale 1ns/1ns
`default_nettype none
module xfer_checker
#(
	parameter int LOCK_TICKS = 5,
	parameter int STAB_TICKS = 5,
	parameter int TICK_CYCLES = 4
)
(
	input wire        ref_clk_i,
	input wire        rst_n_i,
	input wire        output_contactor_closed_ack_i,
	input wire        line_contactor_closed_ack_i,
	input wire        drive_fault_i,
	input wire        voltage_ok_i,
	input wire        freq_locked_i,
	input wire [7:0]  torque_pct_i,
	input wire        rd_i,
	input wire [15:0] rdata_o,
	input wire        to_line_permit_o,
	input wire        to_line_done_o,
	input wire        mains_contactor_open_cmd_o,
	input wire        to_drive_permit_o,
	input wire        to_drive_done_o,
	input wire        track_line_o,
	input wire        coast_stop_o,
	input wire        run_enable_o,
	input wire        xfer_fail_warn_o
);
	logic [15:0] lk;
	logic [15:0] sb;
	always_ff @(posedge ref_clk_i)
	begin
		lk <= (!rst_n_i || !track_line_o) ? 16'h0000 : lk + 16'h0001;
		sb <= (!rst_n_i || !output_contactor_closed_ack_i) ? 16'h0000 : sb + 16'h0001;
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_up_permit; $rose(to_line_permit_o) |-> lk >= (LOCK_TICKS-1)*TICK_CYCLES; endproperty
	a_up_permit: assert property (p_up_permit) else $error("up permit early");
	property p_up_done; $rose(to_line_done_o) |-> line_contactor_closed_ack_i; endproperty
	a_up_done: assert property (p_up_done) else $error("up done no ack");
	property p_dn_permit; $rose(to_drive_permit_o) |-> voltage_ok_i; endproperty
	a_dn_permit: assert property (p_dn_permit) else $error("down permit");
	property p_unlatch; $rose(mains_contactor_open_cmd_o) |-> freq_locked_i &&
		torque_pct_i >= 8'h19 && sb >= (STAB_TICKS-1)*TICK_CYCLES; endproperty
	a_unlatch: assert property (p_unlatch) else $error("unlatch early");
	property p_dn_done; $rose(to_drive_done_o) |-> !line_contactor_closed_ack_i
		##[0:8] !(mains_contactor_open_cmd_o || to_drive_permit_o); endproperty
	a_dn_done: assert property (p_dn_done) else $error("down done");
	property p_fault; $rose(drive_fault_i) |-> ##[1:40] coast_stop_o; endproperty
	a_fault: assert property (p_fault) else $error("no coast stop");
	property p_coast; coast_stop_o |-> !run_enable_o; endproperty
	a_coast: assert property (p_coast) else $error("run in coast");
	property p_rd_idle; !$past(rd_i) |-> rdata_o == 16'h0000; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data stray");
	c_up: cover property ($rose(to_line_done_o));
	c_dn: cover property ($rose(to_drive_done_o));
	c_warn: cover property ($rose(xfer_fail_warn_o));
endmodule // xfer_checker
bind sync_transfer_handshake xfer_checker #(.LOCK_TICKS(LOCK_TICKS),
	.STAB_TICKS(STAB_TICKS), .TICK_CYCLES(TICK_CYCLES)) xfer_checker_i (
	.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.output_contactor_closed_ack_i(output_contactor_closed_ack_i),
	.line_contactor_closed_ack_i(line_contactor_closed_ack_i),
	.drive_fault_i(drive_fault_i), .voltage_ok_i(voltage_ok_i),
	.freq_locked_i(freq_locked_i), .torque_pct_i(torque_pct_i),
	.to_line_permit_o(to_line_permit_o), .to_line_done_o(to_line_done_o),
	.mains_contactor_open_cmd_o(mains_contactor_open_cmd_o),
	.to_drive_permit_o(to_drive_permit_o), .to_drive_done_o(to_drive_done_o),
	.track_line_o(track_line_o), .coast_stop_o(coast_stop_o),
	.run_enable_o(run_enable_o), .xfer_fail_warn_o(xfer_fail_warn_o));
`default_nettype wire

// File: plc_model.sv
// Controller model driving the transfer handshake
`timescale 1ns/1ns
`default_nettype none
module plc_model
#(
	parameter int GAP = 1000
)
(
	input  wire        ref_clk_i,
	input  wire        rst_n_i,
	input  wire  [4:0] flags_i,
	input  wire        fault_i,
	output logic [4:0] hs_o
);
	logic [4:0] seen = 5'h00;
	initial hs_o = 5'h00;
	always @(posedge ref_clk_i)
		seen <= rst_n_i ? (seen | flags_i) : 5'h00;
	task automatic step(input int i, input logic v);
		@(posedge ref_clk_i);
		hs_o[i] <= v;
		repeat (GAP) @(posedge ref_clk_i);
	endtask
	task automatic wait_flag(input int i);
		for (int n = 0; n < 4000 && !flags_i[i]; n++)
			@(posedge ref_clk_i);
	endtask
	task automatic up_xfer;
		step(3, 1);
		step(0, 1);
		step(1, 1);
		wait_flag(0);
		step(2, 1);
		wait_flag(1);
		step(0, 0);
		step(3, 0);
		step(1, 0);
		step(2, 0);
	endtask
	task automatic down_xfer(input logic ack);
		step(2, 1);
		step(4, 1);
		step(0, 1);
		wait_flag(3);
		if (ack)
		begin
			step(1, 1);
			wait_flag(2);
			if (!fault_i)
				step(2, 0);
			wait_flag(4);
			step(4, 0);
		end
	endtask
endmodule // plc_model
`default_nettype wire

// File: tb_sync_transfer_handshake.sv
// Testbench for the transfer handshake sequencer
`timescale 1ns/1ns
`default_nettype none
`include "sync_xfer_regs.vh"
module tb_sync_transfer_handshake;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        fault = 1'b0;
	logic [7:0]  torque = 8'h19;
	logic        volt = 1'b1;
	logic        ph_in = 1'b1;
	logic        locked = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	wire  [4:0]  hs;
	wire  [8:0]  q;
	wire  [15:0] rdata;
	wire  [15:0] pw;
	wire  [15:0] sp;
	wire  [15:0] fo;
	logic [15:0] sp_seen = 16'h0000;
	logic [15:0] fo_seen = 16'h0000;
	int          n_errors = 0;
	int          checks_done = 0;
	always #5 clk = ~clk;
	// Last non-zero setpoint and offset the design applied
	always @(posedge clk)
	begin
		if (sp != 16'h0000)
			sp_seen <= sp;
		if (fo != 16'h0000)
			fo_seen <= fo;
	end
	sync_transfer_handshake #(.LOCK_TICKS(5), .STAB_TICKS(5),
		.XFER_TO_TICKS(2500), .TICK_CYCLES(4)) sync_transfer_handshake_i (
		.ref_clk_i(clk), .rst_n_i(rst_n), .to_line_request_i(hs[3]),
		.to_drive_request_i(hs[4]), .run_request_in_i(hs[0]),
		.output_contactor_closed_ack_i(hs[1]),
		.line_contactor_closed_ack_i(hs[2]), .drive_fault_i(fault),
		.voltage_ok_i(volt), .phase_in_window_i(ph_in),
		.freq_locked_i(locked),
		.torque_pct_i(torque), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata), .to_line_permit_o(q[0]),
		.to_line_done_o(q[1]), .mains_contactor_open_cmd_o(q[2]),
		.to_drive_permit_o(q[3]), .to_drive_done_o(q[4]), .track_line_o(q[5]),
		.coast_stop_o(q[6]), .run_enable_o(q[7]), .xfer_fail_warn_o(q[8]),
		.phase_setpoint_o(sp), .phase_window_o(pw), .freq_offset_o(fo));
	plc_model plc_model_i (.ref_clk_i(clk), .rst_n_i(rst_n),
		.flags_i(q[4:0]), .fault_i(fault), .hs_o(hs));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1 chk(pw, `RV_PHASE_WIN);
		rd_chk(`A_PHASE_OFS, `RV_PHASE_OFS);
		rd_chk(`A_FREQ_OFS, `RV_FREQ_OFS);
		rd_chk(4'hf, 16'h0000);
		wr_reg(`A_PHASE_OFS, 16'h0400);
		rd_chk(`A_PHASE_OFS, `LIM_PHASE_OFS);
		wr_reg(`A_FREQ_OFS, 16'hff00);
		rd_chk(`A_FREQ_OFS, 16'hff9c);
		wr_reg(`A_PHASE_WIN, 16'h0033);
		rd_chk(`A_PHASE_WIN, `LIM_PHASE_WIN);
		wr_reg(`A_PHASE_OFS, `RV_PHASE_OFS);
		wr_reg(`A_FREQ_OFS, `RV_FREQ_OFS);
		wr_reg(`A_CTRL, 16'h0002);
		rd_chk(`A_CTRL, 16'h0002);
		wr_reg(`A_CTRL, 16'h0000);
		$display("register test done");
		plc_model_i.up_xfer();
		chk({11'h0, plc_model_i.seen}, 16'h0003);
		chk(sp_seen, `RV_PHASE_OFS);
		$display("up transfer test done");
		plc_model_i.down_xfer(1'b1);
		chk({11'h0, plc_model_i.seen}, 16'h001f);
		chk(fo_seen, `RV_FREQ_OFS);
		chk({13'h0, q[7], q[3:2]}, 16'h0004);
		plc_model_i.step(0, 0);
		plc_model_i.step(1, 0);
		$display("down transfer test done");
		fault <= 1'b1;
		repeat (60) @(posedge clk);
		chk({14'h0, q[7:6]}, 16'h0001);
		fault <= 1'b0;
		repeat (60) @(posedge clk);
		wr_reg(`A_CTRL, 16'h0001);
		repeat (60) @(posedge clk);
		chk({15'h0, q[6]}, 16'h0000);
		$display("fault test done");
		volt <= 1'b0;
		plc_model_i.down_xfer(1'b0);
		chk({15'h0, q[3]}, 16'h0000);
		volt <= 1'b1;
		repeat (10400) @(posedge clk);
		chk({14'h0, q[8], q[3]}, 16'h0002);
		plc_model_i.step(0, 0);
		plc_model_i.step(4, 0);
		plc_model_i.step(2, 0);
		wr_reg(`A_CTRL, 16'h0001);
		repeat (20) @(posedge clk);
		chk({15'h0, q[8]}, 16'h0000);
		rd_chk(`A_STATUS, 16'h0038);
		$display("timeout test done");
		final_report;
	end
	initial
	begin
		repeat (60000) @(posedge clk);
		n_errors++;
		final_report;
	end
endmodule // tb_sync_transfer_handshake
`default_nettype wire
